// ==== rtl/sod_pkg.sv ====
// Package for the stop-mode and oscillator-stop-detect block
package sod_pkg;
	localparam logic [31:0] SOD_CPU_FREQ_HZ   = 32'd125_000_000;
	// Register byte addresses on the Avalon-MM slave
	localparam logic [3:0]  SOD_ADDR_CLKCTL   = 4'h0;
	localparam logic [3:0]  SOD_ADDR_DETECT   = 4'h4;
	localparam logic [3:0]  SOD_ADDR_WAKECFG  = 4'h8;
	localparam logic [3:0]  SOD_ADDR_STATUS   = 4'hc;
	// Clock-control field positions
	localparam int          SOD_B_STOP        = 0;
	localparam int          SOD_B_DIV8        = 1;
	localparam int          SOD_B_SUBDRV      = 2;
	localparam int          SOD_B_MAINDRV     = 3;
	localparam int          SOD_B_SUBSEL      = 4;
	localparam int          SOD_B_PINFN       = 5;
	localparam int          SOD_B_SUBEN       = 6;
	localparam int          SOD_B_LSOFF       = 7;
	localparam int          SOD_B_MAINSTOP    = 8;
	localparam int          SOD_B_PSTOPWAIT   = 9;
	localparam int          SOD_B_HSEN        = 10;
	localparam int          SOD_B_HSSEL       = 11;
	localparam logic [11:0] SOD_CLKCTL_RST    = 12'h0_88;
	// Detect register: [1:0] enable field, [2] on-chip selected, [3] main stopped
	localparam logic [1:0]  SOD_DET_ON        = 2'h3;
	localparam logic [1:0]  SOD_DET_OFF       = 2'h0;
	// Main-clock stop: no edge seen for this many system cycles
	localparam logic [7:0]  SOD_MAIN_TIMEOUT  = 8'h40;
	localparam int          SOD_NUM_WAKE      = 10;

	// Wake sources, order of the o_wake_src / i_irq vector
	typedef struct packed {
		logic mon2;
		logic mon1;
		logic serial;
		logic timer_ra;
		logic ext3;
		logic ext1;
		logic ext0;
		logic key;
		logic osc_stop;
		logic wdog;
	} sod_irq_t;

	// Qualifiers from the peripherals for stop-mode wake
	typedef struct packed {
		logic ext0_filter_on;
		logic ext1_filter_on;
		logic ext3_filter_on;
		logic ra_event_mode;
		logic ra_filter_on;
		logic serial_ext_clk;
		logic monitor1_filter_disable;
		logic monitor2_filter_disable;
	} sod_qual_t;

	typedef enum logic [1:0] {SOD_RUN, SOD_STOP, SOD_WAKE} sod_state_t;
endpackage : sod_pkg

// ==== rtl/sod_stop_ctrl.sv ====
// Stop-mode controller and main-oscillator stop detector
// Summary of operation
// R1: Writing one to stop_all_clocks_bit halts every oscillator and the clocks they feed; the low-speed osc is not stopped and follows its off bit.
// R2: Stop entry forces div8 select and both oscillator drive-high bits to one together.
// R3: Peripherals clocked from external pins keep running during stop mode.
// R4: Stop mode ends only on reset or an accepted peripheral interrupt.
// R5: Key inputs always wake; external interrupts 0, 1, 3 wake only unfiltered.
// R6: Timer RA wakes only in event-counter mode with its filter off.
// R7: Serial interrupt wakes only when the interface uses an external clock.
// R8: Voltage-monitor interrupt wakes only when its filter-disable bit is one.
// R9: Interrupt wake restarts the CPU clock, then runs the waking interrupt.
// R10: After interrupt wake, CPU clock is the prior system clock divided by eight.
// R11: Pins hold in stop; oscillator output pin driven high when configured, else input.
// R12: Stop detection is active only when detect_enable_field equals 11b.
// R13: Main clock loss while sourcing CPU sets both flags, starts low-speed osc, interrupts.
// R14: Software keeps detection off when main clock is 2 MHz or less.
// R15: Stop-detect interrupt shares a vector; cause read from its flags.
// R16: Software clears detection before stop mode or main oscillator stop changes.
// R17: Software clears periph_clock_stop_in_wait before wait with detection on.
// R18: Software switches back to main clock; hardware never switches back.
// R19: Software picks fallback oscillator before writing 11b to the detect field.
// R20: Four bytes are prefetched past halt; software disables self-rewrite, pads no-ops.
// R21: Software sets wake priorities, masks others, enables interrupts before stop.
// R22: Wake qualification is combinational on requests and needs no running clock.
module sod_stop_ctrl #(
	parameter int NUM_WAKE = sod_pkg::SOD_NUM_WAKE  // Wake source count
) (
	input  wire logic              i_clk_sys,      // System clock, 125 MHz
	input  wire logic              i_sys_rst,      // Synchronous reset, active high
	input  wire logic [3:0]        i_avs_address,  // Avalon byte address
	input  wire logic              i_avs_read,     // Read request
	input  wire logic              i_avs_write,    // Write request
	input  wire logic [31:0]       i_avs_writedata,// Write data
	output logic      [31:0]       o_avs_readdata, // Read data
	output logic                   o_avs_waitrequest, // Wait request
	input  wire sod_pkg::sod_irq_t i_irq,          // Raw peripheral requests
	input  wire sod_pkg::sod_qual_t i_qual,        // Peripheral wake qualifiers
	input  wire logic              i_main_osc_tick,// Main oscillator edge, sampled
	input  wire logic              i_pin_out,      // Shared osc pin port data
	input  wire logic              i_pin_oe,       // Shared osc pin port enable
	output logic                   o_osc_run,      // Oscillators enabled
	output logic                   o_cpu_clk_en,   // CPU clock gate
	output logic                   o_periph_clk_en,// Peripheral clock gate
	output logic                   o_ext_periph_en,// Externally clocked peripherals run
	output logic                   o_cpu_div8,     // CPU clock divided by 8
	output logic                   o_onchip_sel,   // On-chip osc sources system clock
	output logic                   o_low_speed_on, // Low-speed on-chip osc running
	output logic                   o_pin_hold,     // Pin states frozen
	output logic                   o_osc_pin_out,  // Shared osc pin output value
	output logic                   o_osc_pin_oe,   // Shared osc pin output enable
	output logic                   o_irq_osc_stop, // Stop-detect request, level
	output logic [NUM_WAKE-1:0]    o_wake_src      // Source that caused the wake
);
	typedef struct packed {
		sod_pkg::sod_state_t st;
		logic [11:0]         clkctl;
		logic [1:0]          det_en;
		logic                onchip_flag;
		logic                stopped_flag;
		logic [7:0]          tmo;
		logic [NUM_WAKE-1:0] wake_src;
		logic                rd_done;
		logic [31:0]         rdata;
		logic                pin_out;
		logic                pin_oe;
	} sod_state_reg_t;

	sod_state_reg_t s_reg;
	sod_state_reg_t s_next;
	logic [NUM_WAKE-1:0] wake_ok;
	logic                wake_any;
	logic                wr_hit;
	logic                main_lost;

	function automatic logic [31:0] sod_pad(input logic [11:0] v);
		sod_pad = {20'h0_0000, v};
	endfunction : sod_pad

	// Combinational qualification, valid with clocks halted
	always_comb begin
		wake_ok = '0;
		wake_ok[2] = i_irq.key;                                                      // R5
		wake_ok[3] = i_irq.ext0 && !i_qual.ext0_filter_on;                           // R5
		wake_ok[4] = i_irq.ext1 && !i_qual.ext1_filter_on;                           // R5
		wake_ok[5] = i_irq.ext3 && !i_qual.ext3_filter_on;                           // R5
		wake_ok[6] = i_irq.timer_ra && i_qual.ra_event_mode && !i_qual.ra_filter_on; // R6
		wake_ok[7] = i_irq.serial && i_qual.serial_ext_clk;                          // R7
		wake_ok[8] = i_irq.mon1 && i_qual.monitor1_filter_disable;                   // R8
		wake_ok[9] = i_irq.mon2 && i_qual.monitor2_filter_disable;                   // R8
		wake_any = |wake_ok;                                                         // R22
	end

	// A write lands at the edge where the master samples waitrequest low
	assign wr_hit    = i_avs_write && s_reg.rd_done;
	assign main_lost = (s_reg.tmo == sod_pkg::SOD_MAIN_TIMEOUT);

	always_comb begin
		s_next = s_reg;
		s_next.rd_done = 1'b0;
		// Every request except a read in stop mode is answered one cycle after it is first seen
		if ((i_avs_read || i_avs_write) && !s_reg.rd_done) begin
			s_next.rd_done = 1'b1;
		end
		if (i_avs_read && !s_reg.rd_done) begin
			s_next.rd_done = 1'b1;
			unique case (i_avs_address)
				sod_pkg::SOD_ADDR_CLKCTL:  s_next.rdata = sod_pad(s_reg.clkctl);
				sod_pkg::SOD_ADDR_DETECT:  s_next.rdata = {28'h000_0000, s_reg.stopped_flag,
					s_reg.onchip_flag, s_reg.det_en};
				sod_pkg::SOD_ADDR_WAKECFG: s_next.rdata = 32'(s_reg.wake_src);
				sod_pkg::SOD_ADDR_STATUS:  s_next.rdata = 32'(wake_ok);
				default:                   s_next.rdata = 32'h0000_0000;
			endcase
		end
		if (wr_hit) begin
			unique case (i_avs_address)
				sod_pkg::SOD_ADDR_CLKCTL: s_next.clkctl = i_avs_writedata[11:0];
				sod_pkg::SOD_ADDR_DETECT: begin
					s_next.det_en = i_avs_writedata[1:0];
					if (!i_avs_writedata[2]) s_next.onchip_flag = 1'b0;
					if (!i_avs_writedata[3]) s_next.stopped_flag = 1'b0;
				end
				default: ;
			endcase
		end
		// Main clock watchdog counter
		if (i_main_osc_tick || s_reg.clkctl[sod_pkg::SOD_B_MAINSTOP])
			s_next.tmo = 8'h00;
		else if (!main_lost)
			s_next.tmo = s_reg.tmo + 8'h01;
		// Detection and flags; the set wins over a clear in the same cycle
		if (s_reg.det_en == sod_pkg::SOD_DET_ON && main_lost                       // R12
			&& !s_reg.onchip_flag && !s_reg.clkctl[sod_pkg::SOD_B_SUBSEL]) begin
			s_next.onchip_flag = 1'b1;                                              // R13
			s_next.stopped_flag = 1'b1;                                             // R13
			s_next.clkctl[sod_pkg::SOD_B_LSOFF] = 1'b0;                             // R13
		end
		// Only reset or a write clearing the on-chip flag returns the clock to the main oscillator
		unique case (s_reg.st)
			sod_pkg::SOD_RUN: begin
				if (s_next.clkctl[sod_pkg::SOD_B_STOP]) begin
					s_next.st = sod_pkg::SOD_STOP;                                   // R1 R20
					s_next.clkctl[sod_pkg::SOD_B_DIV8]    = 1'b1;                    // R2
					s_next.clkctl[sod_pkg::SOD_B_SUBDRV]  = 1'b1;                    // R2
					s_next.clkctl[sod_pkg::SOD_B_MAINDRV] = 1'b1;                    // R2
					s_next.pin_out = i_pin_out;                                      // R11
					s_next.pin_oe  = i_pin_oe;                                       // R11
					if (!s_next.clkctl[sod_pkg::SOD_B_PINFN]
						|| (s_next.clkctl[sod_pkg::SOD_B_SUBSEL]
						&& !s_next.clkctl[sod_pkg::SOD_B_SUBEN])) begin
						s_next.pin_oe = 1'b0;                                        // R11
					end else begin
						s_next.pin_out = 1'b1;                                       // R11
						s_next.pin_oe  = 1'b1;                                       // R11
					end
				end
			end
			sod_pkg::SOD_STOP: begin
				s_next.tmo = 8'h00;
				if (wake_any) begin                                                  // R4
					s_next.st = sod_pkg::SOD_WAKE;
					s_next.wake_src = wake_ok;
					s_next.clkctl[sod_pkg::SOD_B_STOP] = 1'b0;
				end
			end
			sod_pkg::SOD_WAKE: s_next.st = sod_pkg::SOD_RUN;                         // R9
		endcase
		if (i_sys_rst) begin
			s_next = '0;
			s_next.st = sod_pkg::SOD_RUN;
			s_next.clkctl = sod_pkg::SOD_CLKCTL_RST;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		s_reg <= s_next;
	end

	logic stopped;
	assign stopped = (s_reg.st == sod_pkg::SOD_STOP);

	// Registered outputs
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_osc_run         <= 1'b1;
			o_cpu_clk_en      <= 1'b1;
			o_periph_clk_en   <= 1'b1;
			o_ext_periph_en   <= 1'b1;
			o_cpu_div8        <= 1'b0;
			o_onchip_sel      <= 1'b0;
			o_low_speed_on    <= !sod_pkg::SOD_CLKCTL_RST[sod_pkg::SOD_B_LSOFF];
			o_pin_hold        <= 1'b0;
			o_osc_pin_out     <= 1'b0;
			o_osc_pin_oe      <= 1'b0;
			o_irq_osc_stop    <= 1'b0;
			o_wake_src        <= '0;
			o_avs_readdata    <= 32'h0000_0000;
			o_avs_waitrequest <= 1'b1;
		end else begin
			o_osc_run         <= s_next.st != sod_pkg::SOD_STOP;                     // R1
			o_cpu_clk_en      <= s_next.st == sod_pkg::SOD_RUN;                      // R9
			o_periph_clk_en   <= s_next.st != sod_pkg::SOD_STOP;                     // R1
			o_ext_periph_en   <= 1'b1;                                               // R3
			o_cpu_div8        <= s_next.clkctl[sod_pkg::SOD_B_DIV8];                 // R10
			o_onchip_sel      <= s_next.onchip_flag;                                 // R18
			o_low_speed_on    <= !s_next.clkctl[sod_pkg::SOD_B_LSOFF];
			o_pin_hold        <= s_next.st == sod_pkg::SOD_STOP;                     // R11
			o_osc_pin_out     <= s_next.pin_out;
			o_osc_pin_oe      <= s_next.pin_oe;
			o_irq_osc_stop    <= s_next.stopped_flag
				|| (s_next.det_en == sod_pkg::SOD_DET_ON && s_next.onchip_flag);     // R15
			o_wake_src        <= s_next.wake_src;
			o_avs_readdata    <= s_next.rdata;
			o_avs_waitrequest <= !((i_avs_read && !s_reg.rd_done && !stopped) || (i_avs_write && !s_reg.rd_done))
				|| (s_reg.rd_done);
		end
	end
endmodule : sod_stop_ctrl

// ==== test/sod_stop_ctrl_props.sv ====
// Assertions for the stop-mode controller and main-oscillator stop detector
module sod_stop_ctrl_props (
	input wire logic               i_clk_sys,         // Clock
	input wire logic               i_sys_rst,         // Reset
	input wire logic [3:0]         i_avs_address,     // Address
	input wire logic               i_avs_write,       // Write
	input wire logic [31:0]        i_avs_writedata,   // Write data
	input wire logic               o_avs_waitrequest, // Wait
	input wire sod_pkg::sod_irq_t  i_irq,             // Requests
	input wire sod_pkg::sod_qual_t i_qual,            // Qualifiers
	input wire logic               i_main_osc_tick,   // Main tick
	input wire logic               o_osc_run,         // Osc on
	input wire logic               o_cpu_clk_en,      // CPU gate
	input wire logic               o_ext_periph_en,   // Ext periph
	input wire logic               o_cpu_div8,        // Div by 8
	input wire logic               o_onchip_sel,      // On-chip source
	input wire logic               o_low_speed_on,    // Low osc
	input wire logic               o_pin_hold,        // Pin hold
	input wire logic               o_osc_pin_out,     // Pin value
	input wire logic               o_osc_pin_oe,      // Pin enable
	input wire logic               o_irq_osc_stop     // Stop request
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	logic wq;
	// Qualified wake request, worked out independently of the design
	assign wq = i_irq.key | (i_irq.ext0 & ~i_qual.ext0_filter_on) | (i_irq.ext1 & ~i_qual.ext1_filter_on)
		| (i_irq.ext3 & ~i_qual.ext3_filter_on) | (i_irq.timer_ra & i_qual.ra_event_mode & ~i_qual.ra_filter_on)
		| (i_irq.serial & i_qual.serial_ext_clk) | (i_irq.mon1 & i_qual.monitor1_filter_disable)
		| (i_irq.mon2 & i_qual.monitor2_filter_disable);
	sequence s_stop_req;
		i_avs_write && !o_avs_waitrequest && i_avs_address == sod_pkg::SOD_ADDR_CLKCTL && i_avs_writedata[0];
	endsequence
	sequence s_halted;
		!o_osc_run && !o_cpu_clk_en && o_cpu_div8;
	endsequence
	stop_entry_a: assert property (s_stop_req |-> ##[1:3] s_halted) else $error("stop not entered");
	ext_run_a: assert property (o_ext_periph_en) else $error("ext periph stopped");
	stop_hold_a: assert property (!o_osc_run && !wq && !$past(wq) |=> !o_osc_run) else $error("woke without cause");
	wake_fast_a: assert property (!o_osc_run && wq |-> ##[1:4] o_osc_run) else $error("wake missed");
	wake_div_a: assert property ($rose(o_osc_run) |-> ##[0:2] (o_cpu_clk_en && o_cpu_div8))
		else $error("wake clock not div8");
	pin_hold_a: assert property (!o_osc_run |-> o_pin_hold) else $error("pins not held");
	osc_pin_a: assert property (o_pin_hold && o_osc_pin_oe |-> o_osc_pin_out) else $error("osc pin not high");
	detect_set_a: assert property ($rose(o_irq_osc_stop) |-> o_onchip_sel && o_low_speed_on)
		else $error("detect flags missing");
	tick_live_a: assert property (i_main_osc_tick |=> !$rose(o_irq_osc_stop)) else $error("stop seen while ticking");
	keep_onchip_a: assert property (o_onchip_sel && !i_avs_write |=> o_onchip_sel) else $error("auto switch back");
	wait_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("waitrequest low twice");
endmodule : sod_stop_ctrl_props

bind sod_stop_ctrl sod_stop_ctrl_props i_sod_stop_ctrl_props (.*);

// ==== test/sod_stop_ctrl_tb.sv ====
// Self-checking bench for the stop-mode controller and stop detector
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module sod_stop_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic               i_clk_sys = 1'b0;
	logic               i_sys_rst = 1'b1;
	logic [3:0]         adr = 4'h0;
	logic               rd = 1'b0;
	logic               wr = 1'b0;
	logic               tick = 1'b0;
	logic               tick_run = 1'b1;
	logic [31:0]        wd = 32'h0000_0000;
	logic [31:0]        rdata, got;
	logic [9:0]         wake_src;
	logic               wait_req, osc_run, cpu_en, div8, onchip, low_on, hold, pin_out, pin_oe, irq_stop;
	logic               periph_en;
	sod_pkg::sod_irq_t  irq = '0;
	sod_pkg::sod_qual_t qual = '0;
	int                 error_cnt = 0;
	int                 total_checks = 0;
	logic [18:0]        rows [18];
	always #4 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) tick <= tick_run & ~tick;
	sod_stop_ctrl i_sod_stop_ctrl (
		.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_irq(irq), .i_qual(qual),
		.i_main_osc_tick(tick), .i_pin_out(1'b0), .i_pin_oe(1'b1), .o_osc_run(osc_run), .o_cpu_clk_en(cpu_en),
		.o_periph_clk_en(periph_en), .o_ext_periph_en(), .o_cpu_div8(div8), .o_onchip_sel(onchip),
		.o_low_speed_on(low_on),
		.o_pin_hold(hold), .o_osc_pin_out(pin_out), .o_osc_pin_oe(pin_oe), .o_irq_osc_stop(irq_stop),
		.o_wake_src(wake_src));
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask : cyc
	// One Avalon transfer; holds the request until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wr <= w;
		rd <= ~w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (wait_req !== 1'b0 && n < 100);
		if (n >= 100) error_cnt++;
		got = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge i_clk_sys);
	endtask : bus
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test
	initial begin
		cyc(20000);
		error_cnt++;
		end_of_test();
	end
	initial begin
		// Row: request vector, qualifiers, wake expected
		rows = '{{10'h004, 8'hff, 1'b1}, {10'h008, 8'h00, 1'b1}, {10'h008, 8'h80, 1'b0}, {10'h010, 8'h00, 1'b1},
			{10'h010, 8'h40, 1'b0}, {10'h020, 8'h20, 1'b0}, {10'h020, 8'h00, 1'b1}, {10'h040, 8'h10, 1'b1},
			{10'h040, 8'h18, 1'b0}, {10'h040, 8'h00, 1'b0}, {10'h080, 8'h04, 1'b1}, {10'h080, 8'h00, 1'b0},
			{10'h100, 8'h02, 1'b1}, {10'h100, 8'h00, 1'b0}, {10'h200, 8'h01, 1'b1}, {10'h200, 8'h00, 1'b0},
			{10'h001, 8'hff, 1'b0}, {10'h002, 8'hff, 1'b0}};
		cyc(12);
		i_sys_rst <= 1'b0;
		@(negedge i_clk_sys);
		`CHK({osc_run, cpu_en, low_on, div8, wait_req}, 5'b11001)
		@(posedge i_clk_sys);
		bus(1'b0, sod_pkg::SOD_ADDR_CLKCTL, 32'h0000_0000);
		`CHK(got, 32'(sod_pkg::SOD_CLKCTL_RST))
		bus(1'b1, sod_pkg::SOD_ADDR_WAKECFG, 32'hffff_ffff);
		bus(1'b0, sod_pkg::SOD_ADDR_WAKECFG, 32'h0000_0000);
		`CHK(got, 32'h0000_0000)
		bus(1'b0, 4'h1, 32'h0000_0000);
		`CHK(got, 32'h0000_0000)
		foreach (rows[i]) begin
			cyc(1);
			// Detection is off here; non-waking rows set the osc pin to input
			bus(1'b1, sod_pkg::SOD_ADDR_CLKCTL, rows[i][0] ? 32'h0000_00a9 : 32'h0000_0089);
			cyc(2);
			@(negedge i_clk_sys);
			`CHK({osc_run, cpu_en, periph_en, div8, hold, pin_oe, pin_out}, {5'b00011, {2{rows[i][0]}}})
			@(posedge i_clk_sys);
			irq <= sod_pkg::sod_irq_t'(rows[i][18:9]);
			qual <= sod_pkg::sod_qual_t'(rows[i][8:1]);
			cyc(6);
			@(negedge i_clk_sys);
			`CHK(osc_run, rows[i][0])
			@(posedge i_clk_sys);
			irq <= '0;
			if (rows[i][0]) begin
				`CHK(wake_src, rows[i][18:9])
				bus(1'b0, sod_pkg::SOD_ADDR_WAKECFG, 32'h0000_0000);
				`CHK(got, 32'(rows[i][18:9]))
				bus(1'b0, sod_pkg::SOD_ADDR_CLKCTL, 32'h0000_0000);
				`CHK(got, 32'h0000_00ae)
			end else begin
				i_sys_rst <= 1'b1;
				cyc(2);
				i_sys_rst <= 1'b0;
				@(negedge i_clk_sys);
				`CHK(osc_run, 1'b1)
			end
		end
		cyc(1);
		bus(1'b1, sod_pkg::SOD_ADDR_DETECT, 32'h0000_0001);
		tick_run <= 1'b0;
		cyc(100);
		@(negedge i_clk_sys);
		`CHK(irq_stop, 1'b0)
		@(posedge i_clk_sys);
		tick_run <= 1'b1;
		cyc(4);
		// Tick is far above the minimum rate; low-speed fallback and wait-stop bit stay at reset
		bus(1'b1, sod_pkg::SOD_ADDR_DETECT, 32'h0000_0003);
		tick_run <= 1'b0;
		cyc(100);
		@(negedge i_clk_sys);
		`CHK({irq_stop, onchip, low_on}, 3'b111)
		@(posedge i_clk_sys);
		tick_run <= 1'b1;
		bus(1'b0, sod_pkg::SOD_ADDR_DETECT, 32'h0000_0000);
		`CHK(got[3:0], 4'hf)
		cyc(20);
		@(negedge i_clk_sys);
		`CHK(onchip, 1'b1)
		@(posedge i_clk_sys);
		bus(1'b1, sod_pkg::SOD_ADDR_DETECT, 32'h0000_0000);
		bus(1'b0, sod_pkg::SOD_ADDR_DETECT, 32'h0000_0000);
		`CHK(got[3:0], 4'h0)
		`CHK(irq_stop, 1'b0)
		end_of_test();
	end
endmodule : sod_stop_ctrl_tb
